// ---- include/acs_pkg.sv ----
package acs_pkg;
    // ==========================================================
    // bus and register map (index; byte address is four times it)
    localparam int ADR_W = 18;
    localparam logic [15:0] IDX_RESULT_A = 16'hFFE0;
    localparam logic [15:0] IDX_RESULT_B = 16'hFFE2;
    localparam logic [15:0] IDX_RESULT_C = 16'hFFE4;
    localparam logic [15:0] IDX_RESULT_D = 16'hFFE6;
    localparam logic [15:0] IDX_CTRL_STATUS = 16'hFFE8;
    localparam logic [15:0] IDX_TRIGGER_CTRL = 16'hFFEA;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hFFEC;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hFFEE;
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [7:0] TRIG_RST = 8'h7F;
    localparam logic [6:0] TRIG_RSVD = 7'h7F;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam int TRIG_EN_BIT = 7;
    localparam int END_FLAG_BIT = 7;
    // ==========================================================
    // interrupt status and mask layout
    localparam int IRQ_W = 2;
    localparam int IRQ_CYCLE_BIT = 0;
    localparam int IRQ_CHAN_BIT = 1;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
    // ==========================================================
    // conversion timing
    localparam int SYS_CLK_MHZ = 250;
    localparam int CONV_FAST_NS = 12200;
    localparam int CONV_SLOW_NS = 24200;
    localparam int CONV_FAST_CYC = (CONV_FAST_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CONV_SLOW_CYC = (CONV_SLOW_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int SAR_BITS = 8;
    localparam int SAR_PHASES = SAR_BITS + 1;
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
    localparam logic [7:0] SAR_MSB = 8'h80;
    localparam logic [7:0] SAR_LSB = 8'h01;
    // ==========================================================
    // types
    typedef struct packed {
        logic end_flag;
        logic irq_enable;
        logic start;
        logic scan;
        logic time_select;
        logic group_select;
        logic [1:0] chan_select;
    } acs_csr_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } acs_wb_req_t;

    typedef enum logic [1:0] {
        CORE_IDLE = 2'b00,
        CORE_SAMPLE = 2'b01,
        CORE_BITS = 2'b10
    } acs_core_state_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_CONV = 2'b01,
        SEQ_STORE = 2'b10
    } acs_seq_state_t;
endpackage : acs_pkg

// ---- rtl/acs_sar_core.sv ----
module acs_sar_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // control
    input wire logic start,
    input wire logic abort,
    input wire logic [acs_pkg::CNT_W-1:0] bit_cyc,
    // comparator
    input wire logic cmp_hi,
    // status and data
    output logic busy_ff,
    output logic sampling_ff,
    output logic done_ff,
    output logic [7:0] dac_code_ff,
    output logic [7:0] result_ff
);
    import acs_pkg::*;

    acs_core_state_t state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [7:0] mask_ff;
    logic phase_end;

    assign phase_end = (cnt_ff == bit_cyc);

    // ==========================================================
    // sample phase, then one trial per bit, msb first
    always_ff @(posedge sys_clk) begin
        done_ff <= 1'b0;
        if (reset || abort) begin
            state_ff <= CORE_IDLE;
            cnt_ff <= CNT_ONE;
            mask_ff <= SAR_MSB;
            dac_code_ff <= RESULT_RST;
            result_ff <= RESULT_RST;
            busy_ff <= 1'b0;
            sampling_ff <= 1'b0;
        end else begin
            cnt_ff <= phase_end ? CNT_ONE : cnt_ff + CNT_ONE;
            unique case (state_ff)
                CORE_IDLE: begin
                    cnt_ff <= CNT_ONE;
                    if (start) begin
                        state_ff <= CORE_SAMPLE;
                        busy_ff <= 1'b1;
                        sampling_ff <= 1'b1;
                        mask_ff <= SAR_MSB;
                        result_ff <= RESULT_RST;
                    end
                end
                CORE_SAMPLE: begin
                    if (phase_end) begin
                        state_ff <= CORE_BITS;
                        sampling_ff <= 1'b0;
                        dac_code_ff <= SAR_MSB;
                    end
                end
                CORE_BITS: begin
                    if (phase_end) begin
                        // keep the trial bit when the input is at or above it
                        if (cmp_hi) begin
                            result_ff <= dac_code_ff;
                        end
                        mask_ff <= mask_ff >> 1;
                        dac_code_ff <= (cmp_hi ? dac_code_ff : result_ff) | (mask_ff >> 1);
                        if (mask_ff == SAR_LSB) begin
                            state_ff <= CORE_IDLE;
                            busy_ff <= 1'b0;
                            done_ff <= 1'b1;
                            dac_code_ff <= RESULT_RST;
                        end
                    end
                end
                default: begin
                    state_ff <= CORE_IDLE;
                end
            endcase
        end
    end
endmodule : acs_sar_core

// ---- rtl/acs_top.sv ----
// Operation
// - eight-bit successive approximation result, one of eight analog inputs selected.
// - fastest setting never converts a channel quicker than 12.2 us.
// - single mode performs exactly one conversion per start.
// - scan mode cycles continuously over one to four channels.
// - four 8-bit result registers keep results of up to four channels.
// - interrupt can be requested at the end of each conversion cycle.
// - inputs 0..3 form group 0, inputs 4..7 form group 1.
// - external trigger input may start conversions when selected by software.
// - result registers a..d serve inputs 0/4, 1/5, 2/6, 3/7.
// - result registers are read-only and readable even mid-conversion.
// - result registers clear to zero at reset and in standby.
// - end flag bit 7 clears on writing zero; writing one does nothing.
// - start bit runs converter; single clears after one, scan stays set.
// - end flag sets at single end or scan set end; interrupt if enabled.
// - group bit and two channel bits pick single channel or scan last channel.
// - trigger enabled, falling trigger edge sets start bit; software may too.
module acs_top #(
    parameter int CONV_FAST_CYCLES = acs_pkg::CONV_FAST_CYC,
    parameter int CONV_SLOW_CYCLES = acs_pkg::CONV_SLOW_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic standby,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [acs_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // analog front end
    output logic [2:0] analog_sel,
    output logic sample_hold,
    output logic [7:0] dac_code,
    input wire logic cmp_hi,
    // external trigger
    input wire logic ext_conv_trigger,
    // interrupt
    output logic conv_done_irq
);
    import acs_pkg::*;

    localparam logic [CNT_W-1:0] BIT_FAST_CYC = CNT_W'((CONV_FAST_CYCLES + SAR_PHASES - 1) / SAR_PHASES);
    localparam logic [CNT_W-1:0] BIT_SLOW_CYC = CNT_W'((CONV_SLOW_CYCLES + SAR_PHASES - 1) / SAR_PHASES);

    // ==========================================================
    // declarations
    acs_wb_req_t req;
    acs_csr_t csr_ff;
    acs_csr_t wr_csr;
    acs_seq_state_t seq_ff;
    logic trig_en_ff;
    logic [7:0] result_ff [4];
    logic [IRQ_W-1:0] irq_status_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic [2:0] chan_ff;
    logic core_start_ff;
    logic trig_prev_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic irq_ff;
    logic [2:0] sel_ff;
    logic hold_ff;
    logic [7:0] dac_ff;
    logic clr_all;
    logic req_live;
    logic wr_fire;
    logic [15:0] idx;
    logic wr_csr_hit;
    logic wr_trig_hit;
    logic wr_irq_st_hit;
    logic wr_irq_mask_hit;
    logic trig_fall;
    logic core_sampling;
    logic core_done;
    logic [7:0] core_dac;
    logic [7:0] core_result;
    logic core_abort;
    logic [CNT_W-1:0] bit_cyc;
    logic chan_store;
    logic chan_last;
    logic cycle_end;
    logic single_end;
    logic [2:0] first_chan;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
    assign clr_all = reset || standby;
    assign wr_csr = acs_csr_t'(req.dat[7:0]);

    // ==========================================================
    // wishbone decode
    assign req_live = req.cyc && req.stb;
    assign idx = req.adr[ADR_W-1:2];
    // the write lands on the edge where the master sees ack
    assign wr_fire = req_live && req.we && ack_ff && req.sel[0];
    assign wr_csr_hit = wr_fire && (idx == IDX_CTRL_STATUS);
    assign wr_trig_hit = wr_fire && (idx == IDX_TRIGGER_CTRL);
    assign wr_irq_st_hit = wr_fire && (idx == IDX_IRQ_STATUS);
    assign wr_irq_mask_hit = wr_fire && (idx == IDX_IRQ_MASK);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req_live && !ack_ff;
        end
    end

    // read data captured as ack rises; result registers ignore writes
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_ff <= '0;
        end else if (req_live && !ack_ff) begin
            rdata_ff <= '0;
            unique case (idx)
                IDX_RESULT_A: rdata_ff[7:0] <= result_ff[0];
                IDX_RESULT_B: rdata_ff[7:0] <= result_ff[1];
                IDX_RESULT_C: rdata_ff[7:0] <= result_ff[2];
                IDX_RESULT_D: rdata_ff[7:0] <= result_ff[3];
                IDX_CTRL_STATUS: rdata_ff[7:0] <= csr_ff;
                IDX_TRIGGER_CTRL: rdata_ff[7:0] <= {trig_en_ff, TRIG_RSVD};
                IDX_IRQ_STATUS: rdata_ff[IRQ_W-1:0] <= irq_status_ff;
                IDX_IRQ_MASK: rdata_ff[IRQ_W-1:0] <= irq_mask_ff;
                default: rdata_ff <= '0;
            endcase
        end
    end

    // ==========================================================
    // external trigger edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            trig_prev_ff <= 1'b1;
        end else begin
            trig_prev_ff <= ext_conv_trigger;
        end
    end

    assign trig_fall = trig_en_ff && trig_prev_ff && !ext_conv_trigger;

    // ==========================================================
    // trigger control register
    always_ff @(posedge sys_clk) begin
        if (clr_all) begin
            trig_en_ff <= TRIG_RST[TRIG_EN_BIT];
        end else if (wr_trig_hit) begin
            trig_en_ff <= req.dat[TRIG_EN_BIT];
        end
    end

    // ==========================================================
    // channel selection
    // group bit picks the bank, scans start at its first input
    assign first_chan = {csr_ff.group_select, 2'b00};
    assign chan_last = csr_ff.scan ? (chan_ff[1:0] == csr_ff.chan_select) : 1'b1;
    assign chan_store = (seq_ff == SEQ_STORE);
    assign single_end = chan_store && !csr_ff.scan;
    assign cycle_end = chan_store && chan_last;
    assign core_abort = clr_all || ((seq_ff != SEQ_IDLE) && !csr_ff.start);
    assign bit_cyc = csr_ff.time_select ? BIT_FAST_CYC : BIT_SLOW_CYC;

    // ==========================================================
    // control/status register
    always_ff @(posedge sys_clk) begin
        if (clr_all) begin
            csr_ff <= acs_csr_t'(CSR_RST);
        end else begin
            if (wr_csr_hit) begin
                csr_ff.irq_enable <= wr_csr.irq_enable;
                csr_ff.scan <= wr_csr.scan;
                csr_ff.time_select <= wr_csr.time_select;
                csr_ff.group_select <= wr_csr.group_select;
                csr_ff.chan_select <= wr_csr.chan_select;
            end
            // only a zero clears; hardware set wins
            if (cycle_end) begin
                csr_ff.end_flag <= 1'b1;
            end else if (wr_csr_hit && !req.dat[END_FLAG_BIT]) begin
                csr_ff.end_flag <= 1'b0;
            end
            // trigger beats both hardware and software clear
            if (trig_fall) begin
                csr_ff.start <= 1'b1;
            end else if (single_end) begin
                csr_ff.start <= 1'b0;
            end else if (wr_csr_hit) begin
                csr_ff.start <= wr_csr.start;
            end
        end
    end

    // ==========================================================
    // conversion sequencer
    always_ff @(posedge sys_clk) begin
        if (clr_all) begin
            seq_ff <= SEQ_IDLE;
            chan_ff <= 3'h0;
            core_start_ff <= 1'b0;
        end else begin
            core_start_ff <= 1'b0;
            unique case (seq_ff)
                SEQ_IDLE: begin
                    if (csr_ff.start) begin
                        seq_ff <= SEQ_CONV;
                        core_start_ff <= 1'b1;
                        chan_ff <= csr_ff.scan ? first_chan : {csr_ff.group_select, csr_ff.chan_select};
                    end
                end
                SEQ_CONV: begin
                    if (!csr_ff.start) begin
                        seq_ff <= SEQ_IDLE;
                    end else if (core_done) begin
                        seq_ff <= SEQ_STORE;
                    end
                end
                SEQ_STORE: begin
                    if (!csr_ff.scan) begin
                        seq_ff <= SEQ_IDLE;
                    end else if (!csr_ff.start) begin
                        seq_ff <= SEQ_IDLE;
                    end else begin
                        // next input only after this one is stored
                        seq_ff <= SEQ_CONV;
                        core_start_ff <= 1'b1;
                        chan_ff <= chan_last ? first_chan : chan_ff + 3'h1;
                    end
                end
                default: begin
                    seq_ff <= SEQ_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // result registers, one per channel position
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_result
            always_ff @(posedge sys_clk) begin
                if (clr_all) begin
                    result_ff[g] <= RESULT_RST;
                end else if (core_done && (seq_ff == SEQ_CONV) && (chan_ff[1:0] == 2'(g))) begin
                    result_ff[g] <= core_result;
                end
            end
        end
    endgenerate

    // ==========================================================
    // interrupt status, mask and output
    always_ff @(posedge sys_clk) begin
        if (clr_all) begin
            irq_status_ff <= IRQ_RST;
            irq_mask_ff <= IRQ_RST;
        end else begin
            if (wr_irq_mask_hit) begin
                irq_mask_ff <= req.dat[IRQ_W-1:0];
            end
            for (int i = 0; i < IRQ_W; i++) begin
                if (wr_irq_st_hit && req.dat[i]) begin
                    irq_status_ff[i] <= 1'b0;
                end
            end
            // set wins over a same-cycle clear
            if (cycle_end) begin
                irq_status_ff[IRQ_CYCLE_BIT] <= 1'b1;
            end
            if (chan_store) begin
                irq_status_ff[IRQ_CHAN_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clr_all) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= (csr_ff.end_flag && csr_ff.irq_enable) || (|(irq_status_ff & irq_mask_ff));
        end
    end

    // ==========================================================
    // analog front end drive
    always_ff @(posedge sys_clk) begin
        if (clr_all) begin
            sel_ff <= 3'h0;
            hold_ff <= 1'b0;
            dac_ff <= RESULT_RST;
        end else begin
            sel_ff <= chan_ff;
            hold_ff <= core_sampling;
            dac_ff <= core_dac;
        end
    end

    acs_sar_core u_core (
        .sys_clk(sys_clk),
        .reset(reset),
        .start(core_start_ff),
        .abort(core_abort),
        .bit_cyc(bit_cyc),
        .cmp_hi(cmp_hi),
        .busy_ff(),
        .sampling_ff(core_sampling),
        .done_ff(core_done),
        .dac_code_ff(core_dac),
        .result_ff(core_result)
    );

    // ==========================================================
    // outputs
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign conv_done_irq = irq_ff;
    assign analog_sel = sel_ff;
    assign sample_hold = hold_ff;
    assign dac_code = dac_ff;
endmodule : acs_top

// ---- verification/acs_top_sva.sv ----
module acs_top_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic standby,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [acs_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // analog front end
    input wire logic [2:0] analog_sel,
    input wire logic sample_hold,
    input wire logic [7:0] dac_code,
    input wire logic cmp_hi,
    // trigger and interrupt
    input wire logic ext_conv_trigger,
    input wire logic conv_done_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // bus answer
    chk_ack_one_cycle: assert property (@(posedge sys_clk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
    chk_ack_after_req: assert property (@(posedge sys_clk) disable iff (reset)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("request not answered");
    chk_no_idle_ack: assert property (@(posedge sys_clk) disable iff (reset)
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
    chk_data_upper_zero: assert property (@(posedge sys_clk) disable iff (reset)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("read data above bit 7 not zero");
    // ==========================================================
    // conversion and clearing
    chk_sel_held_sample: assert property (@(posedge sys_clk) disable iff (reset)
        (sample_hold && $past(sample_hold)) |-> $stable(analog_sel)) else $error("channel moved in sample");
    chk_msb_trial_first: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(sample_hold) |-> dac_code inside {8'h80, 8'h00}) else $error("first trial not msb");
    chk_reset_clears_out: assert property (@(posedge sys_clk)
        reset |=> (!wb_ack_o && !conv_done_irq && !sample_hold && dac_code == 8'h00 && analog_sel == 3'h0))
        else $error("outputs not cleared by reset");
    chk_standby_irq_low: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(standby) |-> ##2 !conv_done_irq) else $error("interrupt survives standby");
endmodule : acs_top_chk

bind acs_top acs_top_chk u_chk (.sys_clk(sys_clk), .reset(reset), .standby(standby),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .analog_sel(analog_sel), .sample_hold(sample_hold), .dac_code(dac_code), .cmp_hi(cmp_hi),
    .ext_conv_trigger(ext_conv_trigger), .conv_done_irq(conv_done_irq));

// ---- verification/acs_afe_model.sv ----
module acs_afe_model (
    // converter side
    input wire logic [2:0] analog_sel,
    input wire logic [7:0] dac_code,
    // comparator
    output logic cmp_hi
);
    timeunit 1ns;
    timeprecision 1ps;
    import acs_pkg::*;
    logic [7:0] level;
    // one fixed level per input, bit 2 picks the group
    assign level = 8'h15 + 8'h22 * {5'h0, analog_sel};
    assign cmp_hi = (level >= dac_code);
endmodule : acs_afe_model

// ---- verification/tb_acs_top.sv ----
module tb_acs_top;
    timeunit 1ns;
    timeprecision 1ps;
    import acs_pkg::*;
    localparam int FAST = 27;
    localparam int SLOW = 45;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic standby = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [ADR_W-1:0] wb_adr = '0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [2:0] analog_sel;
    logic sample_hold;
    logic [7:0] dac_code;
    logic cmp_hi;
    logic ext_trig = 1'b1;
    logic conv_done_irq;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int t0;
    int dt;

    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cycles <= cycles + 1;

    acs_top #(.CONV_FAST_CYCLES(FAST), .CONV_SLOW_CYCLES(SLOW)) DUT (
        .sys_clk(sys_clk), .reset(reset), .standby(standby),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .analog_sel(analog_sel), .sample_hold(sample_hold), .dac_code(dac_code), .cmp_hi(cmp_hi),
        .ext_conv_trigger(ext_trig), .conv_done_irq(conv_done_irq));

    acs_afe_model u_afe (.analog_sel(analog_sel), .dac_code(dac_code), .cmp_hi(cmp_hi));

    // ==========================================================
    // report and compare
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_reg

    function automatic logic [7:0] lvl(input int ch);
        return 8'h15 + 8'h22 * 8'(ch);
    endfunction : lvl

    function automatic logic [15:0] ridx(input int ch);
        return IDX_RESULT_A + 16'(2 * (ch % 4));
    endfunction : ridx

    // ==========================================================
    // classic wishbone single cycle
    task automatic xfer(input logic we, input logic [15:0] idx, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= 4'h1;
        wb_dat <= {24'h0, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            bad_count++;
            summarize();
        end
    endtask : xfer

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, idx, d, q);
    endtask : wr

    task automatic rd_chk(input string name, input logic [15:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b0, idx, 8'h00, q);
        chk_reg(name, exp, q);
    endtask : rd_chk

    // poll end flag, bounded
    task automatic wait_end();
        logic [7:0] c;
        int n;
        n = 0;
        do begin
            xfer(1'b0, IDX_CTRL_STATUS, 8'h00, c);
            n++;
        end while (c[END_FLAG_BIT] !== 1'b1 && n < 200);
        dt = cycles - t0;
        if (c[END_FLAG_BIT] !== 1'b1) begin
            bad_count++;
            summarize();
        end
    endtask : wait_end

    initial begin
        repeat (100000) @(posedge sys_clk);
        bad_count++;
        summarize();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) rd_chk("result", ridx(i), 8'h00);
        rd_chk("ctrl_status", IDX_CTRL_STATUS, 8'h00);
        rd_chk("trigger_ctrl", IDX_TRIGGER_CTRL, 8'h7F);
        rd_chk("unmapped", 16'hFFF0, 8'h00);
        wr(IDX_TRIGGER_CTRL, 8'h00);
        rd_chk("trigger_ctrl", IDX_TRIGGER_CTRL, 8'h7F);
        wr(IDX_CTRL_STATUS, 8'h80);
        rd_chk("ctrl_status", IDX_CTRL_STATUS, 8'h00);
        // single fast conversion on every input
        for (int ch = 0; ch < 8; ch++) begin
            wr(IDX_CTRL_STATUS, 8'h68 | 8'(ch));
            t0 = cycles;
            wait_end();
            chk_reg("fast_time", 8'h01, {7'h0, dt >= FAST});
            rd_chk("ctrl_status", IDX_CTRL_STATUS, 8'hC8 | 8'(ch));
            rd_chk("result", ridx(ch), lvl(ch));
            chk_reg("irq", 8'h01, {7'h0, conv_done_irq});
            wr(IDX_CTRL_STATUS, 8'h48 | 8'(ch));
            wr(IDX_CTRL_STATUS, 8'hC8 | 8'(ch));
            rd_chk("ctrl_status", IDX_CTRL_STATUS, 8'h48 | 8'(ch));
            chk_reg("irq", 8'h00, {7'h0, conv_done_irq});
        end
        // slow conversion, interrupt disabled
        wr(IDX_CTRL_STATUS, 8'h25);
        t0 = cycles;
        wait_end();
        chk_reg("slow_time", 8'h01, {7'h0, dt >= SLOW});
        chk_reg("irq", 8'h00, {7'h0, conv_done_irq});
        wr(IDX_CTRL_STATUS, 8'h05);
        rd_chk("irq_status", IDX_IRQ_STATUS, 8'h03);
        wr(IDX_IRQ_MASK, 8'h01);
        rd_chk("irq_mask", IDX_IRQ_MASK, 8'h01);
        chk_reg("irq", 8'h01, {7'h0, conv_done_irq});
        wr(IDX_IRQ_STATUS, 8'h01);
        rd_chk("irq_status", IDX_IRQ_STATUS, 8'h02);
        chk_reg("irq", 8'h00, {7'h0, conv_done_irq});
        wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_IRQ_STATUS, 8'h02);
        rd_chk("irq_status", IDX_IRQ_STATUS, 8'h00);
        // trigger ignored while disabled
        wr(IDX_CTRL_STATUS, 8'h0B);
        ext_trig <= 1'b0;
        repeat (3) @(posedge sys_clk);
        ext_trig <= 1'b1;
        rd_chk("ctrl_status", IDX_CTRL_STATUS, 8'h0B);
        wr(IDX_TRIGGER_CTRL, 8'h80);
        rd_chk("trigger_ctrl", IDX_TRIGGER_CTRL, 8'hFF);
        ext_trig <= 1'b0;
        t0 = cycles;
        wait_end();
        rd_chk("result_d", IDX_RESULT_D, lvl(3));
        ext_trig <= 1'b1;
        // interrupt up before standby so its clearing is visible
        wr(IDX_IRQ_MASK, 8'h03);
        rd_chk("irq_mask", IDX_IRQ_MASK, 8'h03);
        chk_reg("irq", 8'h01, {7'h0, conv_done_irq});
        // standby clears all but bus ack, read data and trigger edge history
        standby <= 1'b1;
        repeat (2) @(posedge sys_clk);
        standby <= 1'b0;
        for (int i = 0; i < 4; i++) rd_chk("result", ridx(i), 8'h00);
        rd_chk("ctrl_status", IDX_CTRL_STATUS, 8'h00);
        rd_chk("trigger_ctrl", IDX_TRIGGER_CTRL, 8'h7F);
        rd_chk("irq_mask", IDX_IRQ_MASK, 8'h00);
        chk_reg("irq", 8'h00, {7'h0, conv_done_irq});
        // scan over inputs 4 to 6
        wr(IDX_CTRL_STATUS, 8'h3E);
        t0 = cycles;
        wait_end();
        for (int i = 0; i < 3; i++) rd_chk("scan_result", ridx(i), lvl(i + 4));
        rd_chk("result_d", IDX_RESULT_D, 8'h00);
        rd_chk("ctrl_status", IDX_CTRL_STATUS, 8'hBE);
        wr(IDX_CTRL_STATUS, 8'h3E);
        wr(IDX_RESULT_A, 8'h5A);
        rd_chk("result_a", IDX_RESULT_A, lvl(4));
        wait_end();
        rd_chk("result_c", IDX_RESULT_C, lvl(6));
        wr(IDX_CTRL_STATUS, 8'h00);
        rd_chk("ctrl_status", IDX_CTRL_STATUS, 8'h00);
        summarize();
    end
endmodule : tb_acs_top
